// File: rtl/mdras_defines.vh
// Purpose: constants for the management serial slave
// Assumes: 125 MHz system clock, link clock sampled as a plain input
// Notes:   frame field lengths, opcodes, register map limits
`ifndef MDRAS_DEFINES_VH
`define MDRAS_DEFINES_VH

// ==========================================================
// frame fields
`define MDRAS_PRE_LEN        6'd32
`define MDRAS_START          2'b01
`define MDRAS_OP_READ        2'b10
`define MDRAS_OP_WRITE       2'b01
`define MDRAS_OP_EXT         2'b00
`define MDRAS_PHY_EXT_RD_BIT 4
`define MDRAS_DATA_LEN       5'd16
// last bit counts of header, turnaround and data fields
`define MDRAS_HDR_LAST       6'd11
`define MDRAS_TA_LAST        6'd1
`define MDRAS_DATA_LAST      6'd15

// ==========================================================
// register map
`define MDRAS_PHYREG_LAST    5'd5
`define MDRAS_PHYREG_C1      5'd29
`define MDRAS_PHYREG_C2      5'd31
`define MDRAS_CFG_LAST       8'hc6
`define MDRAS_CFG_RESET      8'h00
`define MDRAS_PHYREG_RESET   16'h0000

// ==========================================================
// timing
`define MDRAS_CLK_MHZ        125
`define MDRAS_MDC_MAX_MHZ    5
`define MDRAS_MDC_MIN_CYC    (`MDRAS_CLK_MHZ / `MDRAS_MDC_MAX_MHZ)

`endif

// File: rtl/mdras_sync.v
// Purpose: two-flop synchroniser for pin inputs
// Assumes: one clock domain, enable freezes state
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none

module mdras_sync #(
    parameter RST_VAL = 1'b1
) (
    // clock and reset
    input  wire CLOCK,
    input  wire RSTN,
    input  wire CE,
    // data
    input  wire D,
    output wire Q
);

    reg meta_reg;   // first stage
    reg sync_reg;   // second stage

    // ==========================================================
    // two flip-flops in series
    always @(posedge CLOCK) begin
        if (!RSTN) begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end else if (CE) begin
            meta_reg <= D;
            sync_reg <= meta_reg;
        end
    end

    assign Q = sync_reg;

endmodule

`default_nettype wire

// File: rtl/mdras_slave.v
// Purpose: management serial slave with standard and extended frames
// Assumes: controller drives MDC and MDIO, MDC well below CLOCK/2
// Notes:   MDC edges found by sampling; bits taken on MDC rising edge
//
// What this block does
// - standard frame: preamble, start, op, addresses, TA, data
// - eight 16-bit registers: 0..5, 29, 31
// - extended frames share framing; low byte data
// - opcode 00 and phy bit4 one: read
// - opcode 00 and phy bit4 zero: write
// - phy address bit 3 ignored for extended
// - address is phy[2:0] then reg[4:0]
// - read turnaround: controller releases, device drives zero
// - extended registers are eight bits wide
// - extended read returns zero upper byte
// - extended write ignores upper data byte
// - extended reaches 0x00..0xC6 only, not the PHY registers
// - all frames share one data and clock pin
`timescale 1ns/1ps
`default_nettype none
`include "mdras_defines.vh"

module mdras_slave #(
    parameter PHY_ADDR = 5'h01   // standard frame phy address, arbitrary default
) (
    // clock, reset, enable
    input  wire        CLOCK,
    input  wire        RSTN,
    input  wire        CE,
    // management pins
    input  wire        MDC,
    input  wire        MDIO_I,
    output reg         MDIO_O,
    output reg         MDIO_OE,
    // status
    output reg  [7:0]  LAST_ADDR,
    output reg         WR_PULSE
);

    // ==========================================================
    // states, one-hot
    localparam [6:0] S_PRE  = 7'h01;
    localparam [6:0] S_ST   = 7'h02;
    localparam [6:0] S_HDR  = 7'h04;
    localparam [6:0] S_TA   = 7'h08;
    localparam [6:0] S_RD   = 7'h10;
    localparam [6:0] S_WR   = 7'h20;
    localparam [6:0] S_IDLE = 7'h40;

    // ==========================================================
    // storage
    reg  [15:0] phy_mem [0:7];      // standard registers
    reg  [7:0]  cfg_mem [0:255];    // configuration registers
    reg  [6:0]  state_reg;          // frame state
    reg  [5:0]  cnt_reg;            // bit counter
    reg  [11:0] hdr_reg;            // op, phy, reg fields
    reg  [15:0] sh_reg;             // data shifter
    reg         mdc_d_reg;          // previous synced MDC
    reg         ta_drive_reg;       // driving TA zero
    reg         is_rd_reg;          // frame is a read
    reg         is_ext_reg;         // frame is extended
    reg         hit_reg;            // frame addresses us
    wire        mdc_s;              // synced clock
    wire        mdio_s;             // synced data
    wire        rise;               // MDC rising edge
    wire        fall;               // MDC falling edge
    wire [1:0]  op;                 // opcode field
    wire [4:0]  phy_address_field;  // phy address field
    wire [4:0]  register_address_field; // register address field
    wire [7:0]  ext_addr;           // extended address
    reg  [2:0]  phy_idx;            // index into phy_mem
    reg         phy_ok;             // register exists

    mdras_sync #(.RST_VAL(1'b1)) u_sync_mdc (
        .CLOCK (CLOCK), .RSTN (RSTN), .CE (CE), .D (MDC), .Q (mdc_s));
    mdras_sync #(.RST_VAL(1'b1)) u_sync_mdio (
        .CLOCK (CLOCK), .RSTN (RSTN), .CE (CE), .D (MDIO_I), .Q (mdio_s));

    assign rise = mdc_s & ~mdc_d_reg;
    assign fall = ~mdc_s & mdc_d_reg;
    assign op                     = hdr_reg[11:10];
    assign phy_address_field      = hdr_reg[9:5];
    assign register_address_field = hdr_reg[4:0];
    // address from phy[2:0], reg[4:0]; bit 3 unused
    assign ext_addr = {phy_address_field[2:0], register_address_field};

    // ==========================================================
    // standard register decode
    // registers 0..5, 29, 31
    always @* begin
        phy_ok  = 1'b1;
        phy_idx = 3'd0;
        if (register_address_field <= `MDRAS_PHYREG_LAST) begin
            phy_idx = register_address_field[2:0];
        end else if (register_address_field == `MDRAS_PHYREG_C1) begin
            phy_idx = 3'd6;
        end else if (register_address_field == `MDRAS_PHYREG_C2) begin
            phy_idx = 3'd7;
        end else begin
            phy_ok = 1'b0;
        end
    end

    // ==========================================================
    // frame engine
    always @(posedge CLOCK) begin
        if (!RSTN) begin
            state_reg    <= S_PRE;
            cnt_reg      <= 6'd0;
            hdr_reg      <= 12'h000;
            sh_reg       <= 16'h0000;
            mdc_d_reg    <= 1'b1;
            ta_drive_reg <= 1'b0;
            is_rd_reg    <= 1'b0;
            is_ext_reg   <= 1'b0;
            hit_reg      <= 1'b0;
            MDIO_O       <= 1'b1;
            MDIO_OE      <= 1'b0;
            LAST_ADDR    <= 8'h00;
            WR_PULSE     <= 1'b0;
        end else if (CE) begin
            mdc_d_reg <= mdc_s;
            WR_PULSE  <= 1'b0;
            // sample on MDC rise, MSB first
            if (rise) begin
                case (state_reg)
                    S_PRE: begin
                        if (!mdio_s) begin
                            cnt_reg <= 6'd0;
                        end else if (cnt_reg < `MDRAS_PRE_LEN) begin
                            cnt_reg <= cnt_reg + 6'd1;
                        end
                        if (!mdio_s && cnt_reg >= `MDRAS_PRE_LEN) begin
                            state_reg <= S_ST;
                        end
                    end
                    // second start bit must be one
                    S_ST: begin
                        cnt_reg   <= 6'd0;
                        state_reg <= mdio_s ? S_HDR : S_PRE;
                    end
                    // opcode and address fields, 12 bits
                    S_HDR: begin
                        hdr_reg <= {hdr_reg[10:0], mdio_s};
                        cnt_reg <= cnt_reg + 6'd1;
                        if (cnt_reg == `MDRAS_HDR_LAST) begin
                            cnt_reg   <= 6'd0;
                            state_reg <= S_TA;
                        end
                    end
                    // turnaround bits
                    S_TA: begin
                        cnt_reg <= cnt_reg + 6'd1;
                        if (cnt_reg == `MDRAS_TA_LAST) begin
                            cnt_reg   <= 6'd0;
                            state_reg <= is_rd_reg ? S_RD : S_WR;
                        end
                    end
                    // read data is driven, nothing sampled
                    S_RD: begin
                        cnt_reg <= cnt_reg + 6'd1;
                        if (cnt_reg == `MDRAS_DATA_LAST) begin
                            state_reg <= S_IDLE;
                        end
                    end
                    // controller drove TA; collect write data
                    S_WR: begin
                        sh_reg  <= {sh_reg[14:0], mdio_s};
                        cnt_reg <= cnt_reg + 6'd1;
                        if (cnt_reg == `MDRAS_DATA_LAST) begin
                            state_reg <= S_IDLE;
                        end
                    end
                    // idle bit, then hunt for next preamble
                    S_IDLE: begin
                        cnt_reg   <= mdio_s ? 6'd1 : 6'd0;
                        state_reg <= S_PRE;
                    end
                    default: begin
                        state_reg <= S_PRE;
                    end
                endcase
            end
            // decode header once it is complete, during first TA bit
            if (state_reg == S_TA && cnt_reg == 6'd0 && !rise) begin
                is_ext_reg <= (op == `MDRAS_OP_EXT);
                if (op == `MDRAS_OP_EXT) begin
                    is_rd_reg <= phy_address_field[`MDRAS_PHY_EXT_RD_BIT];
                    hit_reg   <= (ext_addr <= `MDRAS_CFG_LAST);
                    LAST_ADDR <= ext_addr;
                end else begin
                    is_rd_reg <= (op == `MDRAS_OP_READ);
                    hit_reg   <= (phy_address_field == PHY_ADDR) && phy_ok &&
                                 (op == `MDRAS_OP_READ || op == `MDRAS_OP_WRITE);
                end
            end
            // write commit at end of the data field
            if (rise && state_reg == S_WR && cnt_reg == `MDRAS_DATA_LAST && hit_reg) begin
                WR_PULSE <= 1'b1;
            end
            // drive changes on MDC falling edge, stable for next rise
            if (fall) begin
                MDIO_OE <= 1'b0;
                MDIO_O  <= 1'b1;
                // drive zero in second TA bit
                if (state_reg == S_TA && cnt_reg == `MDRAS_TA_LAST && is_rd_reg && hit_reg) begin
                    MDIO_OE <= 1'b1;
                    MDIO_O  <= 1'b0;
                    if (is_ext_reg) begin
                        sh_reg <= {8'h00, cfg_mem[ext_addr]};
                    end else begin
                        sh_reg <= phy_mem[phy_idx];
                    end
                end
                // read data, MSB first
                if (state_reg == S_RD && hit_reg) begin
                    MDIO_OE <= 1'b1;
                    MDIO_O  <= sh_reg[15];
                    sh_reg  <= {sh_reg[14:0], 1'b0};
                end
            end
            // release outside TA zero and read data
            if (state_reg == S_PRE || state_reg == S_HDR || state_reg == S_WR) begin
                MDIO_OE <= 1'b0;
            end
        end
    end

    // ==========================================================
    // register storage write
    always @(posedge CLOCK) begin
        if (CE && WR_PULSE) begin
            if (is_ext_reg) begin
                cfg_mem[LAST_ADDR] <= sh_reg[7:0];
            end else begin
                phy_mem[phy_idx] <= sh_reg;
            end
        end
    end

endmodule

`default_nettype wire

// File: dv/mdras_ctrl_model.sv
// Purpose: management controller model on MDC and MDIO
// Assumes: MDC half period of four CLOCK cycles
// Notes:   released line reads as the pull-up level
`timescale 1ns/1ps
`default_nettype none
module mdras_ctrl_model (
    // clock and wire level
    input  wire logic CLOCK,
    input  wire logic MDIO_W,
    // driven pins
    output var  logic MDC,
    output var  logic MDIO_D,
    output var  logic MDIO_E
);
    // clock line stands high between frames
    initial begin
        MDC = 1'b1;
        MDIO_D = 1'b1;
        MDIO_E = 1'b0;
    end
    // 64 ns period, bit set after fall, sampled late in high
    task automatic bit1(input logic oe, input logic v, output logic s);
        MDC <= 1'b0;
        MDIO_E <= oe;
        MDIO_D <= v;
        repeat (4) @(posedge CLOCK);
        MDC <= 1'b1;
        repeat (4) @(posedge CLOCK);
        s = MDIO_W;
    endtask
    // preamble, start, fields, turnaround, data, idle
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd, output logic ta);
        logic [63:0] v;
        logic        rdf;
        logic        s;
        integer      i;
        v = {32'hffffffff, 2'b01, op, phy, ra, 2'b10, wd};
        rdf = (op == 2'b10) || (op == 2'b00 && phy[4]);
        for (i = 63; i >= 0; i--) begin
            bit1(!(rdf && i < 18), v[i], s);
            if (i == 16) ta = s;
            if (i < 16) rd[i] = s;
        end
        bit1(1'b0, 1'b1, s);
    endtask
endmodule
`default_nettype wire

// File: dv/mdras_slave_checker.sv
// Purpose: port assertions for the management slave
// Assumes: MDC period of eight CLOCK cycles
// Notes:   bound into mdras_slave
`timescale 1ns/1ps
`default_nettype none
module mdras_slave_chk (
    // clock and reset
    input  wire logic       CLOCK,
    input  wire logic       RSTN,
    // pins and status
    input  wire logic       MDC,
    input  wire logic       MDIO_O,
    input  wire logic       MDIO_OE,
    input  wire logic [7:0] LAST_ADDR,
    input  wire logic       WR_PULSE
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    logic [8:0] oe_cnt_reg; // cycles the pin has been driven
    // count drive length, cleared when released
    always @(posedge CLOCK) begin
        if (!RSTN || !MDIO_OE) oe_cnt_reg <= 9'h000;
        else oe_cnt_reg <= oe_cnt_reg + 9'h001;
    end
    sequence hold_bit;
        $stable(MDIO_O)[*4];
    endsequence
    reset_vals_a: assert property (disable iff (1'b0) !RSTN |=> !MDIO_OE && MDIO_O && LAST_ADDR == 8'h00 && !WR_PULSE)
        else $error("outputs not at reset values");
    pulse_single_a: assert property (WR_PULSE |=> !WR_PULSE)
        else $error("write pulse longer than one cycle");
    drive_on_fall_a: assert property ($changed(MDIO_OE) || $changed(MDIO_O) |-> !$past(MDC, 2))
        else $error("pin drive changed outside clock low");
    write_no_drive_a: assert property (WR_PULSE |-> !MDIO_OE)
        else $error("pin driven during a write");
    ta_zero_a: assert property ($rose(MDIO_OE) |-> !MDIO_O)
        else $error("turnaround drive not zero");
    drive_length_a: assert property ($fell(MDIO_OE) |-> oe_cnt_reg inside {[9'd132:9'd140]})
        else $error("drive not seventeen bit times");
    bit_hold_a: assert property ($changed(MDIO_O) && MDIO_OE |=> hold_bit)
        else $error("read bit not held");
    pulse_after_rise_a: assert property (WR_PULSE |-> $past(MDC, 2))
        else $error("write committed away from clock rise");
endmodule
bind mdras_slave mdras_slave_chk u_chk (.CLOCK(CLOCK), .RSTN(RSTN), .MDC(MDC), .MDIO_O(MDIO_O),
    .MDIO_OE(MDIO_OE), .LAST_ADDR(LAST_ADDR), .WR_PULSE(WR_PULSE));
`default_nettype wire

// File: dv/tb.sv
// Purpose: self-checking bench for the management slave
// Assumes: standard phy address left at its default 5'h01
// Notes:   each scenario is one task
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic       clock, rstn, ce, mdc, mdio_d, mdio_e, mdio_o, mdio_oe, wr_pulse;
    logic [7:0] last_addr;
    logic [15:0] rd;
    logic       ta;
    integer     bad_count = 0, cmp_count = 0, wr_seen = 0, cyc = 0, i, w0;
    // wire level: device, then controller, else pull-up
    wire mdio_w = mdio_oe ? mdio_o : (mdio_e ? mdio_d : 1'b1);
    mdras_slave u_mdras_slave (.CLOCK(clock), .RSTN(rstn), .CE(ce), .MDC(mdc), .MDIO_I(mdio_w),
        .MDIO_O(mdio_o), .MDIO_OE(mdio_oe), .LAST_ADDR(last_addr), .WR_PULSE(wr_pulse));
    mdras_ctrl_model u_ctrl (.CLOCK(clock), .MDIO_W(mdio_w), .MDC(mdc), .MDIO_D(mdio_d), .MDIO_E(mdio_e));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // count write pulses and cut a hang short
    always @(posedge clock) begin
        if (wr_pulse === 1'b1) wr_seen <= wr_seen + 1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            end_of_test();
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic t_reset();
        check({mdio_oe, mdio_o, wr_pulse, 5'h00, last_addr}, 16'h4000);
        $display("test reset done");
    endtask
    // extended write then read at bounds, bit 3 toggled, junk upper byte
    task automatic t_ext();
        logic [7:0] a [3];
        a = '{8'h00, 8'hc6, 8'h5a};
        for (i = 0; i < 3; i++) begin
            w0 = wr_seen;
            u_ctrl.frame(2'b00, {1'b0, i[0], a[i][7:5]}, a[i][4:0], {8'ha5, a[i] ^ 8'h3c}, rd, ta);
            check(16'(wr_seen - w0), 16'h0001);
            check({8'h00, last_addr}, {8'h00, a[i]});
            u_ctrl.frame(2'b00, {1'b1, ~i[0], a[i][7:5]}, a[i][4:0], 16'h0000, rd, ta);
            check(rd, {8'h00, a[i] ^ 8'h3c});
            check({15'h0000, ta}, 16'h0000);
        end
        w0 = wr_seen;
        u_ctrl.frame(2'b00, 5'b00110, 5'h07, 16'h0011, rd, ta);
        check(16'(wr_seen - w0), 16'h0000);
        $display("test extended done");
    endtask
    // standard registers, then refused register and phy address
    task automatic t_std();
        logic [4:0] r [4];
        r = '{5'd0, 5'd5, 5'd29, 5'd31};
        for (i = 0; i < 4; i++) begin
            w0 = wr_seen;
            u_ctrl.frame(2'b01, 5'h01, r[i], 16'hc3a0 + 16'(i), rd, ta);
            check(16'(wr_seen - w0), 16'h0001);
            u_ctrl.frame(2'b10, 5'h01, r[i], 16'h0000, rd, ta);
            check(rd, 16'hc3a0 + 16'(i));
            check({15'h0000, ta}, 16'h0000);
        end
        u_ctrl.frame(2'b10, 5'h01, 5'd6, 16'h0000, rd, ta);
        check({rd[14:0], ta}, 16'hffff);
        w0 = wr_seen;
        u_ctrl.frame(2'b01, 5'h02, 5'd0, 16'h0bad, rd, ta);
        check(16'(wr_seen - w0), 16'h0000);
        $display("test standard done");
    endtask
    // enable low holds all state: a write sent meanwhile is lost, old data stays
    task automatic t_freeze();
        w0 = wr_seen;
        ce <= 1'b0;
        u_ctrl.frame(2'b00, 5'b00010, 5'h1a, 16'h00ff, rd, ta);
        check(16'(wr_seen - w0), 16'h0000);
        check({8'h00, last_addr}, 16'h00c7);
        ce <= 1'b1;
        u_ctrl.frame(2'b00, 5'b10010, 5'h1a, 16'h0000, rd, ta);
        check(rd, {8'h00, 8'h5a ^ 8'h3c});
        check({15'h0000, ta}, 16'h0000);
        $display("test freeze done");
    endtask
    task automatic end_of_test();
        $display("counts: compared %0d, mismatched %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // reset for six cycles, then the scenarios
    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        t_reset();
        t_ext();
        t_std();
        t_freeze();
        end_of_test();
    end
endmodule
`default_nettype wire
